// file: shared/ssc_pkg.sv
/*
 * Constants for the synthesizer serial control port: address layout,
 * word lengths, load points, field positions and reset values.
 * Assumes a single 100 MHz clock domain in the design that imports it.
 */
package ssc_pkg;

    // Pins brought through the synchroniser
    localparam int SYNC_W = 6;
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_CE = 2;
    localparam int PIN_FMT = 3;
    localparam int PIN_SEL0 = 4;
    localparam int PIN_SEL1 = 5;

    // Two-wire address byte
    localparam logic [4:0] ADDR_FIXED = 5'h18;
    localparam logic [1:0] ADDR_GENERAL = 2'h1;
    localparam logic ADDR_WRITE = 1'b0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Three-wire word lengths and load points (edge counts before the edge)
    localparam logic [4:0] TW_LEN_SHORT = 5'h12;
    localparam logic [4:0] TW_LEN_LONG = 5'h13;
    localparam logic [4:0] TW_LEN_FULL = 5'h1B;
    localparam logic [4:0] TW_BAND_RISES = 5'h04;
    localparam logic [4:0] TW_FREQ_RISES = 5'h13;
    localparam logic [4:0] TW_CNT_MAX = 5'h1F;
    localparam int TW_SHIFT_W = 27;

    // Control field positions, same in control byte and long word tail
    localparam int CF_PUMP = 6;
    localparam int CF_TEST_HI = 5;
    localparam int CF_TEST_LO = 3;
    localparam int CF_RSA = 2;
    localparam int CF_RS_B = 1;
    localparam int CF_OFF = 0;
    localparam int DB_MSB = 7;

    // Reset values
    localparam logic [14:0] FREQ_RST = 15'h0000;
    localparam logic [3:0] BAND_RST = 4'h0;
    localparam logic PUMP_RST = 1'b1;
    localparam logic [2:0] TEST_RST = 3'h1;
    localparam logic RSA_RST = 1'b0;
    localparam logic OFF_RST = 1'b1;

    // Reference divider ratios
    localparam logic [10:0] RATIO_640 = 11'h280;
    localparam logic [10:0] RATIO_1024 = 11'h400;
    localparam logic [10:0] RATIO_512 = 11'h200;

    typedef enum logic [4:0] {
        I2C_IDLE = 5'b00001,
        I2C_ADDR = 5'b00010,
        I2C_ADDR_ACK = 5'b00100,
        I2C_DATA = 5'b01000,
        I2C_DATA_ACK = 5'b10000
    } ssc_i2c_state_type;

    typedef enum logic [3:0] {
        BYTE_DIV_HI = 4'b0001,
        BYTE_DIV_LO = 4'b0010,
        BYTE_CTRL = 4'b0100,
        BYTE_BAND = 4'b1000
    } ssc_byte_kind_type;

endpackage : ssc_pkg

// file: verilog/ssc_pin_sync.sv
/*
 * Two-flop synchronisers with edge detection for the serial port pins.
 * Assumes the pins are asynchronous to clk; edges come from flop 2 and 3.
 */
`timescale 1ns/1ps
module ssc_pin_sync
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Raw pins
    input wire logic [SYNC_W-1:0] pin_in,
    // Synchronised levels and edge pulses
    output logic [SYNC_W-1:0] level,
    output logic [SYNC_W-1:0] rise,
    output logic [SYNC_W-1:0] fall
);

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_pin
            logic meta_r;
            logic stab_r;
            logic prev_r;
            always_ff @(posedge clk) begin
                if (srst) begin
                    meta_r <= 1'b0;
                    stab_r <= 1'b0;
                    prev_r <= 1'b0;
                end else begin
                    meta_r <= pin_in[gi];
                    stab_r <= meta_r;
                    prev_r <= stab_r;
                end
            end
            assign level[gi] = stab_r;
            assign rise[gi] = stab_r & ~prev_r;
            assign fall[gi] = ~stab_r & prev_r;
        end
    endgenerate

endmodule : ssc_pin_sync

// file: verilog/ssc_serial_port.sv
/*
 * Serial control front end of a PLL tuning synthesizer: write-only
 * two-wire slave or three-wire receiver feeding frequency, control and
 * band switch registers. Assumes all pins are asynchronous to clk and
 * that the open-drain data line is resolved outside from sda_oe.
 */
// How it works
// - Format pin high selects three-wire, low selects two-wire write protocol.
// - Acknowledge address byte with fixed upper bits, select bits and write bit.
// - Address select bits come from the decoded address select input.
// - Address with select value 01 is always acknowledged.
// - Data bytes auto-increment so address plus four bytes programs everything.
// - First data byte msb 0 means divider data, 1 means control data.
// - Data bytes keep being accepted and acknowledged until a STOP.
// - Frequency register loads after eighth clock of divider low byte.
// - Control register loads after eighth clock of control byte.
// - Band register loads after eighth clock of band byte.
// - Divider is seven bits of high byte then eight of low byte.
// - Control byte holds pump current, test bits, ratio selects, tuning off.
// - Tuning off 0 enables tuning output, 1 turns it off.
// - Low four band byte bits drive band outputs; upper bits ignored.
// - Ratio 640 when B is 0, 1024 for A0 B1, 512 for both 1.
// - Three-wire data shifts on clock falling edge while enable is high.
// - First four three-wire bits load band register on fifth rising edge.
// - 18 or 19 bit words load frequency when enable falls.
// - 18-bit word clears top divider bit, sets A; 19-bit clears A.
// - Words shorter than 18 bits leave frequency unchanged.
// - 27-bit word loads frequency on 20th rise, control on enable fall.
// - Pump, test, B and tuning off change only on 27-bit words.
// - Reset gives 280 uA pump, tuning off, normal test, parameter B.
`timescale 1ns/1ps
module ssc_serial_port
    import ssc_pkg::*;
#(
    parameter logic RATIO_B_RESET = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_enable_in,
    input wire logic bus_format_select,
    input wire logic [1:0] address_select_input,
    // Frequency register
    output logic [14:0] divider_value_bits,
    // Control register
    output logic pump_current_select,
    output logic [2:0] test_bits,
    output logic ratio_select_a,
    output logic ratio_select_b,
    output logic tuning_off,
    output logic tuning_out_enable,
    output logic [10:0] ref_divider_ratio,
    // Band switch register
    output logic [3:0] band_switch_outputs
);

    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_lvl;
    logic [SYNC_W-1:0] pin_rise;
    logic [SYNC_W-1:0] pin_fall;

    assign pin_raw = {address_select_input, bus_format_select, chip_enable_in,
                      sda_in, scl_in};

    ssc_pin_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pin_in(pin_raw),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    logic scl_l;
    logic sda_l;
    logic ce_l;
    logic i2c_mode;
    logic [1:0] sel_bits;
    assign scl_l = pin_lvl[PIN_SCL];
    assign sda_l = pin_lvl[PIN_SDA];
    assign ce_l = pin_lvl[PIN_CE];
    assign i2c_mode = ~pin_lvl[PIN_FMT];
    assign sel_bits = {pin_lvl[PIN_SEL1], pin_lvl[PIN_SEL0]};

    // Two-wire receiver
    ssc_i2c_state_type st_r;
    logic [3:0] bits_r;
    logic [7:0] sh_r;
    logic oe_r;
    logic first_r;
    ssc_byte_kind_type ptr_r;
    ssc_byte_kind_type kind;
    ssc_byte_kind_type kind_nxt;
    logic addr_match;
    logic byte_done;

    assign addr_match = (sh_r[7:3] == ADDR_FIXED) && (sh_r[0] == ADDR_WRITE)
        && ((sh_r[2:1] == sel_bits) || (sh_r[2:1] == ADDR_GENERAL));
    assign byte_done = (st_r == I2C_DATA) && pin_fall[PIN_SCL]
        && (bits_r == BITS_PER_BYTE);

    always_comb begin
        kind = ptr_r;
        if (first_r) begin
            kind = sh_r[DB_MSB] ? BYTE_CTRL : BYTE_DIV_HI;
        end
        kind_nxt = BYTE_DIV_HI;
        unique case (kind)
            BYTE_DIV_HI: kind_nxt = BYTE_DIV_LO;
            BYTE_DIV_LO: kind_nxt = BYTE_CTRL;
            BYTE_CTRL: kind_nxt = BYTE_BAND;
            BYTE_BAND: kind_nxt = BYTE_DIV_HI;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst || !i2c_mode) begin
            st_r <= I2C_IDLE;
            bits_r <= 4'h0;
            sh_r <= 8'h00;
            oe_r <= 1'b0;
        end else if (scl_l && pin_fall[PIN_SDA]) begin
            st_r <= I2C_ADDR;
            bits_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (scl_l && pin_rise[PIN_SDA]) begin
            st_r <= I2C_IDLE;
            oe_r <= 1'b0;
        end else begin
            unique case (st_r)
                I2C_IDLE: begin
                    oe_r <= 1'b0;
                end
                I2C_ADDR, I2C_DATA: begin
                    if (pin_rise[PIN_SCL]) begin
                        sh_r <= {sh_r[6:0], sda_l};
                        bits_r <= bits_r + 4'h1;
                    end else if (pin_fall[PIN_SCL] && bits_r == BITS_PER_BYTE) begin
                        bits_r <= 4'h0;
                        if (st_r == I2C_DATA) begin
                            st_r <= I2C_DATA_ACK;
                            oe_r <= 1'b1;
                        end else if (addr_match) begin
                            st_r <= I2C_ADDR_ACK;
                            oe_r <= 1'b1;
                        end else begin
                            st_r <= I2C_IDLE;
                        end
                    end
                end
                I2C_ADDR_ACK, I2C_DATA_ACK: begin
                    if (pin_fall[PIN_SCL]) begin
                        oe_r <= 1'b0;
                        st_r <= I2C_DATA;
                    end
                end
            endcase
        end
    end

    // Byte sequencing within one transfer
    always_ff @(posedge clk) begin
        if (srst || st_r == I2C_ADDR_ACK) begin
            first_r <= 1'b1;
            ptr_r <= BYTE_DIV_HI;
        end else if (byte_done) begin
            first_r <= (kind == BYTE_BAND);
            ptr_r <= kind_nxt;
        end
    end

    logic ld_hi;
    logic ld_lo;
    logic ld_ctrl;
    logic ld_band;
    assign ld_hi = byte_done && kind == BYTE_DIV_HI;
    assign ld_lo = byte_done && kind == BYTE_DIV_LO;
    assign ld_ctrl = byte_done && kind == BYTE_CTRL;
    assign ld_band = byte_done && kind == BYTE_BAND;

    logic [6:0] hold_hi_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            hold_hi_r <= 7'h00;
        end else if (ld_hi) begin
            hold_hi_r <= sh_r[6:0];
        end
    end

    // Three-wire receiver
    logic [TW_SHIFT_W-1:0] sh3_r;
    logic [4:0] falls_r;
    logic [4:0] rises_r;
    always_ff @(posedge clk) begin
        if (srst || i2c_mode || pin_rise[PIN_CE]) begin
            sh3_r <= '0;
            falls_r <= 5'h00;
            rises_r <= 5'h00;
        end else if (ce_l) begin
            if (pin_fall[PIN_SCL]) begin
                sh3_r <= {sh3_r[TW_SHIFT_W-2:0], sda_l};
                if (falls_r != TW_CNT_MAX) begin
                    falls_r <= falls_r + 5'h01;
                end
            end
            if (pin_rise[PIN_SCL] && rises_r != TW_CNT_MAX) begin
                rises_r <= rises_r + 5'h01;
            end
        end
    end

    logic tw_band;
    logic tw_freq;
    logic tw_end;
    assign tw_band = !i2c_mode && ce_l && pin_rise[PIN_SCL] && rises_r == TW_BAND_RISES;
    assign tw_freq = !i2c_mode && ce_l && pin_rise[PIN_SCL] && rises_r == TW_FREQ_RISES;
    assign tw_end = !i2c_mode && pin_fall[PIN_CE];

    // Frequency register
    always_ff @(posedge clk) begin
        if (srst) begin
            divider_value_bits <= FREQ_RST;
        end else if (ld_lo) begin
            divider_value_bits <= {hold_hi_r, sh_r};
        end else if (tw_freq) begin
            divider_value_bits <= sh3_r[14:0];
        end else if (tw_end && falls_r == TW_LEN_LONG) begin
            divider_value_bits <= sh3_r[14:0];
        end else if (tw_end && falls_r == TW_LEN_SHORT) begin
            divider_value_bits <= {1'b0, sh3_r[13:0]};
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (srst) begin
            pump_current_select <= PUMP_RST;
            test_bits <= TEST_RST;
            ratio_select_a <= RSA_RST;
            ratio_select_b <= RATIO_B_RESET;
            tuning_off <= OFF_RST;
        end else if (ld_ctrl) begin
            pump_current_select <= sh_r[CF_PUMP];
            test_bits <= sh_r[CF_TEST_HI:CF_TEST_LO];
            ratio_select_a <= sh_r[CF_RSA];
            ratio_select_b <= sh_r[CF_RS_B];
            tuning_off <= sh_r[CF_OFF];
        end else if (tw_end && falls_r == TW_LEN_FULL) begin
            pump_current_select <= sh3_r[CF_PUMP];
            test_bits <= sh3_r[CF_TEST_HI:CF_TEST_LO];
            ratio_select_a <= sh3_r[CF_RSA];
            ratio_select_b <= sh3_r[CF_RS_B];
            tuning_off <= sh3_r[CF_OFF];
        end else if (tw_end && falls_r == TW_LEN_LONG) begin
            ratio_select_a <= 1'b0;
        end else if (tw_end && falls_r == TW_LEN_SHORT) begin
            ratio_select_a <= 1'b1;
        end
    end

    // Derived control outputs, one clock behind the control register
    always_ff @(posedge clk) begin
        if (srst) begin
            tuning_out_enable <= ~OFF_RST;
            ref_divider_ratio <= RATIO_B_RESET ? (RSA_RST ? RATIO_512 : RATIO_1024)
                : RATIO_640;
        end else begin
            tuning_out_enable <= ~tuning_off;
            if (!ratio_select_b) begin
                ref_divider_ratio <= RATIO_640;
            end else if (!ratio_select_a) begin
                ref_divider_ratio <= RATIO_1024;
            end else begin
                ref_divider_ratio <= RATIO_512;
            end
        end
    end

    // Band switch register
    always_ff @(posedge clk) begin
        if (srst) begin
            band_switch_outputs <= BAND_RST;
        end else if (ld_band) begin
            band_switch_outputs <= sh_r[3:0];
        end else if (tw_band) begin
            band_switch_outputs <= sh3_r[3:0];
        end
    end

    // Open-drain acknowledge: only ever pulls low
    always_ff @(posedge clk) begin
        if (srst) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= oe_r;
        end
    end

endmodule : ssc_serial_port

// file: tb/ssc_serial_port_assertions.sv
/* Checker for the serial control port outputs.
   Assumes one clock domain and host pin phases of ten clocks. */
`timescale 1ns/1ps
module ssc_serial_port_chk
    import ssc_pkg::*;
#(
    parameter logic RATIO_B_RESET = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic chip_enable_in,
    input wire logic bus_format_select,
    input wire logic [1:0] address_select_input,
    // Registers
    input wire logic [14:0] divider_value_bits,
    input wire logic pump_current_select,
    input wire logic [2:0] test_bits,
    input wire logic ratio_select_a,
    input wire logic ratio_select_b,
    input wire logic tuning_off,
    input wire logic tuning_out_enable,
    input wire logic [10:0] ref_divider_ratio,
    input wire logic [3:0] band_switch_outputs
);
    default clocking chk_clk @(posedge clk); endclocking
    default disable iff (srst);

    reset_values_a:
    assert property ($fell(srst) |-> pump_current_select && test_bits == 3'h1 && tuning_off
        && ratio_select_b == RATIO_B_RESET && band_switch_outputs == 4'h0)
    else $error("reset values wrong");
    tune_enable_a:
    assert property ($stable(tuning_off) |-> tuning_out_enable == !tuning_off)
    else $error("tuning enable wrong");
    ratio_map_a:
    assert property ($stable(ratio_select_a) && $stable(ratio_select_b) |-> ref_divider_ratio
        == (!ratio_select_b ? 11'h280 : (ratio_select_a ? 11'h200 : 11'h400)))
    else $error("ratio wrong");
    div_load_ack_a:
    assert property ($changed(divider_value_bits) && !bus_format_select |=> $rose(sda_oe))
    else $error("divider load off ack");
    ctrl_load_ack_a:
    assert property ($changed({pump_current_select, test_bits, ratio_select_a, ratio_select_b,
        tuning_off}) && !bus_format_select |=> $rose(sda_oe))
    else $error("control load off ack");
    band_load_ack_a:
    assert property ($changed(band_switch_outputs) && !bus_format_select |=> $rose(sda_oe))
    else $error("band load off ack");
    ack_hold_a:
    assert property ($rose(sda_oe) |-> !scl_in ##1 sda_oe [*8])
    else $error("ack not held");
    ack_mode_a:
    assert property (bus_format_select && $past(bus_format_select, 8) |-> !sda_oe)
    else $error("ack in three-wire");
    tw_ctrl_a:
    assert property ($changed({pump_current_select, test_bits, ratio_select_a, ratio_select_b,
        tuning_off}) && bus_format_select |-> !chip_enable_in && $past(chip_enable_in, 8))
    else $error("control load off enable fall");
    ack_low_a:
    assert property (sda_oe |-> !sda_out)
    else $error("ack level wrong");
endmodule : ssc_serial_port_chk

bind ssc_serial_port ssc_serial_port_chk #(.RATIO_B_RESET(RATIO_B_RESET)) chk (.clk, .srst,
    .scl_in,
    .sda_in, .sda_out, .sda_oe, .chip_enable_in, .bus_format_select, .address_select_input,
    .divider_value_bits, .pump_current_select, .test_bits, .ratio_select_a,
    .ratio_select_b, .tuning_off, .tuning_out_enable, .ref_divider_ratio,
    .band_switch_outputs);

// file: tb/ssc_host_model.sv
/* Host controller model driving two-wire or three-wire frames.
   Assumes pins change on the falling clock edge, ten clocks a phase. */
`timescale 1ns/1ps
module ssc_host_model (
    // Clock
    input wire logic clk,
    // Device pull-down
    input wire logic sda_oe,
    // Host pins
    output logic scl,
    output logic sda_drv,
    output logic ce,
    output logic fmt,
    output logic [1:0] addr_sel,
    // Resolved data line
    output logic sda_line
);
    // Open drain with pull-up
    assign sda_line = sda_drv & ~sda_oe;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        ce = 1'b0;
        fmt = 1'b0;
        addr_sel = 2'h2;
    end
    task automatic ph;
        repeat (10) @(negedge clk);
    endtask : ph
    task automatic mode(input logic f, input logic [1:0] a);
        fmt = f;
        addr_sel = a;
        scl = ~f;
        ph();
        ph();
    endtask : mode
    task automatic start;
        sda_drv = 1'b0;
        ph();
        scl = 1'b0;
        ph();
    endtask : start
    task automatic stop;
        sda_drv = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_drv = 1'b1;
        ph();
    endtask : stop
    task automatic clk_bit(input logic d, output logic seen);
        sda_drv = d;
        ph();
        scl = 1'b1;
        ph();
        seen = ~sda_line;
        scl = 1'b0;
        ph();
    endtask : clk_bit
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], ack);
        end
        clk_bit(1'b1, ack);
    endtask : wbyte
    task automatic ce_drop;
        ce = 1'b0;
        sda_drv = 1'b1;
        ph();
    endtask : ce_drop
    task automatic tw(input int n, input logic [26:0] w, input logic drop);
        logic seen;
        ce = 1'b1;
        ph();
        for (int i = n - 1; i >= 0; i--) begin
            clk_bit(w[i], seen);
        end
        if (drop) begin
            ce_drop();
        end
    endtask : tw
endmodule : ssc_host_model

// file: tb/ssc_serial_port_bench.sv
/* Bench for the serial control port: frame sequences with expected
   register values. Assumes ssc_host_model drives every pin. */
`timescale 1ns/1ps
module ssc_serial_port_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic scl, sda_drv, ce, fmt, ack, sda_oe, sdo, pump, rsa, rs_b, off, ten;
    logic [1:0] addr_sel;
    logic [2:0] tb3;
    logic [3:0] band;
    logic [10:0] ratio;
    logic [14:0] div;
    wire logic sda_line;
    int bad_count = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    ssc_host_model host (.clk, .sda_oe, .scl, .sda_drv, .ce, .fmt, .addr_sel, .sda_line);
    ssc_serial_port uut (.clk, .srst, .scl_in(scl), .sda_in(sda_line), .sda_out(sdo),
        .sda_oe, .chip_enable_in(ce), .bus_format_select(fmt),
        .address_select_input(addr_sel), .divider_value_bits(div),
        .pump_current_select(pump), .test_bits(tb3), .ratio_select_a(rsa),
        .ratio_select_b(rs_b), .tuning_off(off), .tuning_out_enable(ten),
        .ref_divider_ratio(ratio), .band_switch_outputs(band));
    task automatic chk(input string nm, input logic [14:0] exp, input logic [14:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wb(input logic [7:0] b, input logic exp);
        host.wbyte(b, ack);
        chk("ack", 15'(exp), 15'(ack));
        chk("sda_out", 15'h0000, 15'(sdo));
    endtask : wb
    // Control fields packed pump, test, rsa, rsb, off
    task automatic ctl(input logic [6:0] e, input logic [10:0] r);
        chk("ctrl", 15'(e), 15'({pump, tb3, rsa, rs_b, off}));
        chk("ratio", 15'(r), 15'(ratio));
        chk("tune_en", 15'(!e[0]), 15'(ten));
    endtask : ctl
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #400000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        ctl(7'h4B, 11'h400);
        host.mode(1'b0, 2'h2);
        host.start();
        wb(8'hC4, 1'b1);
        wb(8'h5A, 1'b1);
        chk("div", 15'h0000, div);
        wb(8'h3C, 1'b1);
        chk("div", 15'h5A3C, div);
        wb(8'h8E, 1'b1);
        ctl(7'h0E, 11'h200);
        wb(8'hF5, 1'b1);
        chk("band", 15'h0005, 15'(band));
        wb(8'h12, 1'b1);
        wb(8'h34, 1'b1);
        chk("div", 15'h1234, div);
        host.stop();
        host.start();
        wb(8'hC6, 1'b0);
        host.stop();
        host.start();
        wb(8'hC5, 1'b0);
        host.stop();
        host.start();
        wb(8'hC2, 1'b1);
        wb(8'hF2, 1'b1);
        wb(8'h0A, 1'b1);
        ctl(7'h72, 11'h400);
        chk("band", 15'h000A, 15'(band));
        host.stop();
        // Address select levels 3 and 0
        host.mode(1'b0, 2'h3);
        host.start();
        wb(8'hC6, 1'b1);
        host.stop();
        host.start();
        wb(8'hC4, 1'b0);
        host.stop();
        host.mode(1'b0, 2'h0);
        host.start();
        wb(8'hC0, 1'b1);
        host.stop();
        host.mode(1'b1, 2'h2);
        host.tw(19, {8'h0, 4'h6, 15'h1234}, 1'b1);
        chk("band", 15'h0006, 15'(band));
        chk("div", 15'h1234, div);
        chk("rsa", 15'h0000, 15'(rsa));
        host.tw(18, {9'h0, 4'h9, 14'h2ABC}, 1'b1);
        chk("div", 15'h2ABC, div);
        chk("rsa", 15'h0001, 15'(rsa));
        host.tw(17, {10'h0, 17'h1FFFF}, 1'b1);
        chk("div", 15'h2ABC, div);
        chk("band", 15'h000F, 15'(band));
        host.tw(27, {4'h3, 15'h4321, 1'b0, 7'h08}, 1'b0);
        chk("div", 15'h4321, div);
        ctl(7'h76, 11'h200);
        host.ce_drop();
        ctl(7'h08, 11'h280);
        host.tw(19, {8'h0, 4'h1, 15'h7FFF}, 1'b1);
        ctl(7'h08, 11'h280);
        host.tw(18, {9'h0, 4'h2, 14'h0123}, 1'b1);
        ctl(7'h0C, 11'h280);
        tally_and_finish();
    end
endmodule : ssc_serial_port_bench
